// ---- verilog/clkout_top.sv ----
// Peripheral clock output with its control register on Avalon-MM.
// Assumes i_sleep and i_match come from logic on i_clock; the pin
// input crosses two flip-flops.
`timescale 1ns/1ns
`include "clkout_params.svh"

// Summary of operation
// - The enable bit chooses clock output or plain I/O for the pin.
// - Writing enable 1 starts the clock on the pin and 0 stops it.
// - Select 0/1 gives clock/4, 2 gives clock/8, 3 half timer rate.
// - Sleep turns the clock output off whatever the enable says.
// - The output clock is made from and in step with the system clock.
// - Control bit 0 is not stored and reads as zero.
// - Serial mode bits 7..5 and enable bit 1 are stored separately.
module clkout_top
  import clkout_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic [31:0]      o_readdata,
  output logic             o_waitrequest,
  // System events
  input  wire logic        i_sleep,
  input  wire logic        i_match,
  // Shared pin
  input  wire logic        i_pin,
  output logic             o_pin,
  output logic             o_pin_oe_n,
  // Serial unit settings
  output logic [2:0]       o_serial_mode,
  output logic             o_serial_enable
);
  // ************************************************************
  // State
  // ************************************************************
  logic [2:0]  serial_unit_mode;
  logic        serial_unit_enable;
  logic        clkout_enable;
  clk_source_t source_select;
  logic        io_out;
  logic        io_oe;
  logic        pin_meta;
  logic        pin_sync;
  logic        ack;
  logic [2:0]  next_mode;
  logic        next_serial_en;
  logic        next_enable;
  clk_source_t next_select;
  logic        next_io_out;
  logic        next_io_oe;
  logic        next_ack;
  logic [31:0] next_readdata;
  logic        next_pin;
  logic        next_oe_n;
  logic        wave;
  logic        run;
  logic [7:0]  ctrl_view;

  // ************************************************************
  // Divider
  // ************************************************************
  // sleep stops clock
  assign run = clkout_enable & ~i_sleep;

  clkout_divider u_div (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_run    (run),
    .i_source (source_select),
    .i_match  (i_match),
    .o_wave   (wave)
  );

  // ************************************************************
  // Register file
  // ************************************************************
  // bit 0 reads zero
  assign ctrl_view = {serial_unit_mode, clkout_enable,
                      source_select, serial_unit_enable, 1'b0};

  // Bus decode; one wait cycle keeps read data registered
  always_comb begin
    next_mode      = serial_unit_mode;
    next_serial_en = serial_unit_enable;
    next_enable    = clkout_enable;
    next_select    = source_select;
    next_io_out    = io_out;
    next_io_oe     = io_oe;
    next_readdata  = o_readdata;
    next_ack       = 1'b0;
    if ((i_read || i_write) && !ack) begin
      next_ack = 1'b1;
      if (i_read) begin
        // Unmapped addresses read zero
        unique case (i_address)
          `CTRL_OFFSET: next_readdata = {24'h0, ctrl_view};
          `PIN_OFFSET:  next_readdata = {29'h0, pin_sync, io_oe, io_out};
          default:      next_readdata = 32'h0;
        endcase
      end
    end
    // Write lands only at the edge where waitrequest is seen low
    if (i_write && ack) begin
      if (i_byteenable[0]) begin
        if (i_address == `CTRL_OFFSET) begin
          next_mode      = i_writedata[`MODE_HI:`MODE_LO];
          next_serial_en = i_writedata[`SERIAL_EN_BIT];
          next_enable    = i_writedata[`ENABLE_BIT];
          next_select    = clk_source_t'(
                             i_writedata[`SELECT_HI:`SELECT_LO]);
        end else if (i_address == `PIN_OFFSET) begin
          next_io_out = i_writedata[0];
          next_io_oe  = i_writedata[1];
        end
      end
    end
  end

  always_comb begin
    if (clkout_enable) begin
      next_pin  = wave;
      next_oe_n = 1'b0;
    end else begin
      next_pin  = io_out;
      next_oe_n = ~io_oe;
    end
  end

  // Registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      serial_unit_mode   <= 3'h7;
      serial_unit_enable <= 1'b0;
      clkout_enable      <= 1'b0;
      source_select      <= src_div4a;
      io_out             <= 1'b0;
      io_oe              <= 1'b0;
      ack                <= 1'b0;
      o_readdata         <= 32'h0;
      o_waitrequest      <= 1'b1;
      o_pin              <= 1'b0;
      o_pin_oe_n         <= 1'b1;
      o_serial_mode      <= 3'h7;
      o_serial_enable    <= 1'b0;
      pin_meta           <= 1'b0;
      pin_sync           <= 1'b0;
    end else begin
      serial_unit_mode   <= next_mode;
      serial_unit_enable <= next_serial_en;
      clkout_enable      <= next_enable;
      source_select      <= next_select;
      io_out             <= next_io_out;
      io_oe              <= next_io_oe;
      ack                <= next_ack;
      o_readdata         <= next_readdata;
      o_waitrequest      <= ~next_ack;
      o_pin              <= next_pin;
      o_pin_oe_n         <= next_oe_n;
      o_serial_mode      <= next_mode;
      o_serial_enable    <= next_serial_en;
      pin_meta           <= i_pin;
      pin_sync           <= pin_meta;
    end
  end
endmodule

// ---- verilog/clkout_params.svh ----
// Constants for the peripheral clock output block.
// Assumes inclusion by bare name from the two modules.
`ifndef CLKOUT_PARAMS_SVH
`define CLKOUT_PARAMS_SVH
// Register map (one word per register)
`define CTRL_OFFSET      4'h0
`define PIN_OFFSET       4'h4
// Control register field positions
`define MODE_HI          7
`define MODE_LO          5
`define ENABLE_BIT       4
`define SELECT_HI        3
`define SELECT_LO        2
`define SERIAL_EN_BIT    1
// Control register reset value
`define CTRL_RESET       8'he0
// Half periods of the divided clocks, in system clock cycles
`define HALF_DIV4        3'h2
`define HALF_DIV8        3'h4
`endif

// ---- verilog/clkout_pkg.sv ----
// Types shared by the peripheral clock output block.
// Assumes the params header sits in the include path.
package clkout_pkg;
  typedef enum logic [1:0] {
    src_div4a,
    src_div4b,
    src_div8,
    src_timer
  } clk_source_t;
endpackage

// ---- verilog/clkout_divider.sv ----
// Clock divider and timer toggle for the clock output pin.
// Assumes the timer match pulse is already in the i_clock domain.
`timescale 1ns/1ns
`include "clkout_params.svh"
module clkout_divider
  import clkout_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // Control
  input  wire logic        i_run,
  input  wire clk_source_t i_source,
  input  wire logic        i_match,
  // Clock out
  output logic             o_wave
);
  logic [2:0] count;
  logic [2:0] next_count;
  logic       next_wave;
  logic [2:0] half;

  // Next count and wave
  always_comb begin
    half       = (i_source == src_div8) ? `HALF_DIV8 : `HALF_DIV4;
    next_count = count;
    next_wave  = o_wave;
    if (!i_run) begin
      // Park low so the pin never shows a runt when restarted
      next_count = 3'h0;
      next_wave  = 1'b0;
    end else if (i_source == src_timer) begin
      next_count = 3'h0;
      if (i_match) begin
        next_wave = ~o_wave;
      end
    end else if (count + 3'h1 >= half) begin
      next_count = 3'h0;
      next_wave  = ~o_wave;
    end else begin
      next_count = count + 3'h1;
    end
  end

  // Registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count  <= 3'h0;
      o_wave <= 1'b0;
    end else begin
      count  <= next_count;
      o_wave <= next_wave;
    end
  end
endmodule

// ---- bench/clkout_top_assertions.sv ----
// Checker for the clock output block, bound onto clkout_top.
// Assumes default Avalon-MM timing; sees the top ports only.
`timescale 1ns/1ns
module clkout_top_chk (
  input wire logic        i_clock, i_rst_n, i_read, i_write, i_sleep,
  input wire logic        i_match, o_waitrequest, o_pin, o_pin_oe_n,
  input wire logic        o_serial_enable,
  input wire logic [3:0]  i_address, i_byteenable,
  input wire logic [31:0] i_writedata, o_readdata,
  input wire logic [2:0]  o_serial_mode
);
  // ************
  // Shadow state
  // ************
  logic [7:0] ctrl, next_ctrl;
  logic [3:0] quiet, next_quiet;
  logic       wr, run;
  assign wr  = !o_waitrequest && i_write && i_address == 4'h0
               && i_byteenable[0];
  assign run = ctrl[4] && quiet == 4'hf;
  // Setup changes restart the settle count, so shapes wait out 15 cycles
  always_comb begin
    next_ctrl  = wr ? i_writedata[7:0] : ctrl;
    next_quiet = (wr || i_sleep) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
  end
  // Shadow registers
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl  <= 8'he0;
      quiet <= 4'h0;
    end else begin
      ctrl  <= next_ctrl;
      quiet <= next_quiet;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_div4; o_pin[*2] ##1 !o_pin[*2] ##1 o_pin; endsequence
  sequence s_div8; o_pin[*4] ##1 !o_pin[*4] ##1 o_pin; endsequence
  a_wait_one: assert property (
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest ##1 o_waitrequest)
    else $error("waitrequest not low for one cycle");
  a_read_zero: assert property (
    !o_waitrequest && i_read && i_address == 4'h0
    |-> o_readdata[31:8] == 24'h0 && !o_readdata[0])
    else $error("unused control bits read nonzero");
  // Shapes stop being checked once the setup changes under them
  a_div4_shape: assert property (
    disable iff (!i_rst_n || !run)
    run && !ctrl[3] && $rose(o_pin) |-> s_div4)
    else $error("divide by 4 wave wrong");
  a_div8_shape: assert property (
    disable iff (!i_rst_n || !run)
    run && ctrl[3:2] == 2'h2 && $rose(o_pin) |-> s_div8)
    else $error("divide by 8 wave wrong");
  a_timer_toggle: assert property (
    disable iff (!i_rst_n || !run)
    run && ctrl[3:2] == 2'h3
    |-> ##2 (o_pin != $past(o_pin)) == $past(i_match, 2))
    else $error("timer toggle wrong");
  a_pin_driven: assert property (
    run |-> !o_pin_oe_n)
    else $error("pin not driven while enabled");
  a_sleep_low: assert property (
    i_sleep [*3] ##0 ctrl[4] |-> !o_pin)
    else $error("clock runs in sleep");
  a_serial_copy: assert property (
    quiet > 4'h1 |-> o_serial_mode == ctrl[7:5]
    && o_serial_enable == ctrl[1])
    else $error("serial fields wrong");
endmodule
bind clkout_top clkout_top_chk chk (.*);

// ---- bench/clock_sink.sv ----
// Far-side consumer that counts clock edges on the shared pin.
// Assumes its level output feeds the pin input of the block.
`timescale 1ns/1ns
module clock_sink (
  input  wire logic i_clock,
  input  wire logic i_pin,
  input  wire logic i_pin_oe_n,
  output logic      o_level,
  output int        o_rises
);
  logic last  = 1'b0;
  logic held  = 1'b0;
  int   count = 0;
  // Released pin shows the inverse of the last driven level, never stale
  assign o_level = i_pin_oe_n ? !held : i_pin;
  assign o_rises = count;
  // Rises counted only while the block drives the pin
  always @(posedge i_clock) begin
    last <= o_level;
    if (!i_pin_oe_n) held <= i_pin;
    if (!i_pin_oe_n && o_level && !last) count <= count + 1;
  end
endmodule

// ---- bench/test_peripheral_clock_output.sv ----
// Self-checking bench for the clock output block.
// Assumes design, checker and clock sink are compiled first.
`timescale 1ns/1ns
module test_peripheral_clock_output;
  logic        i_clock = 1'b0, i_rst_n = 1'b0, i_read = 1'b0;
  logic        i_write = 1'b0, i_sleep = 1'b0, i_match = 1'b0, m;
  logic        i_pin, o_pin, o_pin_oe_n, o_waitrequest, o_serial_enable;
  logic [3:0]  i_address = 4'h0, i_byteenable = 4'h1;
  logic [31:0] i_writedata = 32'h0, o_readdata, rd;
  logic [2:0]  o_serial_mode;
  int          rises, miscompares = 0, compares = 0, n, got, base;
  int          seed = 32'h3de7;
  clkout_top dut (.*);
  clock_sink far (.i_clock(i_clock), .i_pin(o_pin),
    .i_pin_oe_n(o_pin_oe_n), .o_level(i_pin), .o_rises(rises));
  always #5 i_clock = !i_clock;
  // ***********
  // Bench tasks
  // ***********
  task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    @(posedge i_clock);
    i_address   <= a;
    i_writedata <= d;
    i_write     <= wr;
    i_read      <= !wr;
    do @(posedge i_clock); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read  <= 1'b0;
  endtask
  function automatic int want(logic [1:0] s, int k);
    return s == 2'h3 ? k / 2 : (s == 2'h2 ? 8 : 16);
  endfunction
  // Even match count keeps the rise count free of the start level
  task automatic window(logic [1:0] s);
    repeat (20) @(posedge i_clock);
    base = rises;
    n = 0;
    repeat (64) begin
      @(posedge i_clock);
      m = s == 2'h3 && $random(seed) % 2 != 0;
      i_match <= m;
      n += m;
    end
    got = rises - base;
    @(posedge i_clock);
    i_match <= n % 2 != 0;
    n += n % 2;
    @(posedge i_clock);
    i_match <= 1'b0;
    repeat (4) @(posedge i_clock);
    if (s == 2'h3) got = rises - base;
    $display("window sel %0d done, rises %0d", s, got);
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    results;
  end
  // *************
  // Main sequence
  // *************
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", 32'he0, rd);
    bus(1'b0, 4'hc, 32'h0);
    chk("unmapped", 32'h0, rd);
    repeat (4) begin
      n = $random(seed);
      bus(1'b1, 4'h0, n);
      bus(1'b0, 4'h0, 32'h0);
      chk("ctrl", n & 32'hfe, rd);
      chk("serial", {n[7:5], n[1]}, {o_serial_mode, o_serial_enable});
    end
    // Write with lane 0 off must leave the control register alone
    base = rd;
    i_byteenable <= 4'h0;
    bus(1'b1, 4'h0, 32'hff);
    i_byteenable <= 4'h1;
    bus(1'b0, 4'h0, 32'h0);
    chk("be0 ignored", base, rd);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 4'h0, {24'h0, 4'hb, s[1:0], 2'h2});
      window(s[1:0]);
      chk("rises", want(s[1:0], n), got);
      chk("oe_n", 32'h0, o_pin_oe_n);
    end
    i_sleep <= 1'b1;
    window(2'h0);
    chk("sleep rises", 32'h0, got);
    i_sleep <= 1'b0;
    bus(1'b1, 4'h0, 32'h0);
    window(2'h0);
    chk("off rises", 32'h0, got);
    // Clock off: pin is plain I/O, driven high and read back synced
    bus(1'b1, 4'h4, 32'h3);
    repeat (4) @(posedge i_clock);
    bus(1'b0, 4'h4, 32'h0);
    chk("pin reg", 32'h7, rd);
    chk("pin out", 32'h1, o_pin);
    results;
  end
endmodule
